//--- src/acc_status_pkg.sv
// Shared constants for the accessory status and interrupt flag block
package acc_status_pkg;
   // Register offsets on the internal register read port
   localparam logic [7:0] AUX_STATUS_OFS = 8'h05;
   localparam logic [7:0] IRQ_FLAGS_OFS = 8'h06;
   // Reset values
   localparam logic [7:0] AUX_STATUS_RST = 8'h00;
   localparam logic [7:0] IRQ_FLAGS_RST = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   // Field positions of the auxiliary status register
   localparam int POWERED_HS_BIT = 7;
   localparam int THERMAL_CMP_BIT = 6;
   localparam int SUCCESSIVE_APPROX_COMPARATOR_STATE_BIT = 5;
   localparam int BTN_THR_CMP_BIT = 4;
   localparam int SPARE_BTN_BIT = 0;
   // Field positions of the interrupt flag register
   localparam int BTN_REQ_IRQ_BIT = 5;
   localparam int JACK_CHG_IRQ_BIT = 1;
   // Flag bits fed by outside event pulses rather than local edge detectors
   localparam logic [7:0] EXT_EVENT_BITS = 8'hDD;
   // Synchroniser depth for pin-level inputs
   localparam int SYNC_STAGES = 2;
endpackage : acc_status_pkg

//--- src/accessory_status_irq_flags.sv
// Auxiliary status register and clear-on-read interrupt flags of the jack manager
// Overview of operation
// - Powered headset flag is 1 above the detect threshold, 0 below it.
// - Thermal, successive-approx and button-threshold comparator bits mirror comparators unlatched.
// - Spare button flag forced to 0 when bypass open or mic above threshold.
// - In bypass, spare flag is 1 when low-gain result exceeds top threshold.
// - Spare flag updates only in bypass mode on low-gain converter results.
// - Button request flag sets on both edges of button request state in bypass.
// - Jack change flag sets on both edges of the debounced jack detect input.
// - A flag drives the interrupt only while its mask bit is 1.
`timescale 1ns/10ps
module accessory_status_irq_flags #(
   parameter int DATA_WIDTH = 8
) (
   input wire logic i_clk, // 100 MHz block clock
   input wire logic i_rstn, // Async reset, active low
   input wire logic i_ce, // Clock enable, freezes state when low
   input wire logic i_rd_stb, // Register read strobe, one cycle
   input wire logic [7:0] i_rd_addr, // Register read offset
   output logic [7:0] o_rd_data, // Read data, held until next read
   output logic o_rd_valid, // Read data valid pulse
   input wire logic [DATA_WIDTH-1:0] i_sense_voltage, // Sense resistor voltage result
   input wire logic [DATA_WIDTH-1:0] i_headset_threshold, // Headset detect threshold
   input wire logic i_thermal_cmp, // Analog thermal comparator
   input wire logic i_successive_approx_comparator_state, // Analog successive-approx comparator
   input wire logic i_btn_thr_cmp, // Analog button threshold comparator
   input wire logic i_mic_over_thr, // Analog: mic voltage above selected level
   input wire logic i_bypass_closed, // Bypass switch closed (bypass mode)
   input wire logic [DATA_WIDTH-1:0] i_second_result, // Second converter result
   input wire logic i_second_valid, // Second result update pulse
   input wire logic i_low_gain, // Second result taken at low gain
   input wire logic [DATA_WIDTH-1:0] i_top_threshold, // Top button threshold
   input wire logic i_button_request, // Button request state level
   input wire logic i_jack_detect, // Debounced jack detect level
   input wire logic [7:0] i_ext_events, // Event pulses for remaining flag bits
   input wire logic [7:0] i_irq_mask, // Mask register, 1 = not masked
   output logic o_irq // Interrupt request, active high
);
   // Synchronised analog comparator levels
   logic [3:0] cmp_sync;
   logic thermal_s;
   logic sar_s;
   logic btn_thr_s;
   logic mic_over_s;

   // Registers and their next-state values
   logic powered_hs_q;
   logic powered_hs_d;
   logic spare_btn_q;
   logic spare_btn_d;
   logic btn_req_q;
   logic jack_q;
   logic edge_init_q;
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic [7:0] rd_data_q;
   logic [7:0] rd_data_d;
   logic rd_valid_q;
   logic irq_q;

   // Combinational terms
   logic [7:0] aux_status;
   logic [7:0] flag_set;
   logic [7:0] flag_clr;
   logic btn_edge;
   logic jack_edge;
   logic rd_aux;
   logic rd_flags;
   logic spare_block;
   logic spare_update;

   // Comparators arrive from the analog side, asynchronous to the clock
   level_sync #(
      .WIDTH(4)
   ) u_cmp_sync (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_ce(i_ce),
      .i_async({i_thermal_cmp, i_successive_approx_comparator_state, i_btn_thr_cmp, i_mic_over_thr}),
      .o_sync(cmp_sync)
   );

   assign thermal_s = cmp_sync[3];
   assign sar_s = cmp_sync[2];
   assign btn_thr_s = cmp_sync[1];
   assign mic_over_s = cmp_sync[0];

   // Address decode, shared by read data and clear-on-read
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   assign rd_aux = i_rd_stb && hit(i_rd_addr, acc_status_pkg::AUX_STATUS_OFS);
   assign rd_flags = i_rd_stb && hit(i_rd_addr, acc_status_pkg::IRQ_FLAGS_OFS);

   // Headset detect: equal values hold the last decision to avoid chatter
   assign powered_hs_d = (i_sense_voltage > i_headset_threshold) ? 1'b1 :
                         (i_sense_voltage < i_headset_threshold) ? 1'b0 :
                         powered_hs_q;

   // Spare button: forced clear wins over any converter update
   assign spare_block = !i_bypass_closed || mic_over_s;
   assign spare_update = i_bypass_closed && i_low_gain && i_second_valid;
   assign spare_btn_d = spare_block ? 1'b0 :
                        spare_update ? (i_second_result > i_top_threshold) :
                        spare_btn_q;

   // Comparator bits are live; only the synchroniser delays them
   always_comb begin
      aux_status = acc_status_pkg::AUX_STATUS_RST;
      aux_status[acc_status_pkg::POWERED_HS_BIT] = powered_hs_q;
      aux_status[acc_status_pkg::THERMAL_CMP_BIT] = thermal_s;
      aux_status[acc_status_pkg::SUCCESSIVE_APPROX_COMPARATOR_STATE_BIT] = sar_s;
      aux_status[acc_status_pkg::BTN_THR_CMP_BIT] = btn_thr_s;
      aux_status[acc_status_pkg::SPARE_BTN_BIT] = spare_btn_q;
   end

   // Edge detection; first sample after reset is not an edge
   assign btn_edge = edge_init_q && (i_button_request != btn_req_q) && i_bypass_closed;
   assign jack_edge = edge_init_q && (i_jack_detect != jack_q);

   // Flag set and clear terms; set is applied after clear so it wins
   always_comb begin
      flag_set = i_ext_events & acc_status_pkg::EXT_EVENT_BITS;
      flag_set[acc_status_pkg::BTN_REQ_IRQ_BIT] = btn_edge;
      flag_set[acc_status_pkg::JACK_CHG_IRQ_BIT] = jack_edge;
   end

   assign flag_clr = rd_flags ? 8'hFF : 8'h00;
   assign flags_d = (flags_q & ~flag_clr) | flag_set;

   // Read mux; unmapped offsets answer zero
   assign rd_data_d = rd_aux ? aux_status :
                      rd_flags ? flags_q :
                      acc_status_pkg::UNMAPPED_DATA;

   // Status state
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         powered_hs_q <= 1'b0;
         spare_btn_q <= 1'b0;
      end else if (i_ce) begin
         powered_hs_q <= powered_hs_d;
         spare_btn_q <= spare_btn_d;
      end
   end

   // Edge history
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         btn_req_q <= 1'b0;
         jack_q <= 1'b0;
         edge_init_q <= 1'b0;
      end else if (i_ce) begin
         btn_req_q <= i_button_request;
         jack_q <= i_jack_detect;
         edge_init_q <= 1'b1;
      end
   end

   // Flags, read port and interrupt, all registered outputs
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         flags_q <= acc_status_pkg::IRQ_FLAGS_RST;
         rd_data_q <= acc_status_pkg::UNMAPPED_DATA;
         rd_valid_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (i_ce) begin
         flags_q <= flags_d;
         rd_valid_q <= i_rd_stb;
         if (i_rd_stb) begin
            rd_data_q <= rd_data_d;
         end
         irq_q <= |(flags_d & i_irq_mask);
      end
   end

   assign o_rd_data = rd_data_q;
   assign o_rd_valid = rd_valid_q;
   assign o_irq = irq_q;

   initial begin
      if (DATA_WIDTH < 1 || DATA_WIDTH > 16) begin
         $error("accessory_status_irq_flags: DATA_WIDTH out of range");
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   property p_hs_above;
      i_ce && (i_sense_voltage > i_headset_threshold) |=> powered_hs_q;
   endproperty
   a_hs_above: assert property (p_hs_above) else $error("headset flag not set");

   property p_hs_below;
      i_ce && (i_sense_voltage < i_headset_threshold) |=> !powered_hs_q;
   endproperty
   a_hs_below: assert property (p_hs_below) else $error("headset flag not clear");

   property p_thermal_mirror;
      (i_ce && $stable(i_thermal_cmp)) [*3] |->
         aux_status[acc_status_pkg::THERMAL_CMP_BIT] == i_thermal_cmp;
   endproperty
   a_thermal_mirror: assert property (p_thermal_mirror) else $error("thermal bit stale");

   property p_spare_blocked;
      i_ce && (!i_bypass_closed || mic_over_s) |=> !spare_btn_q;
   endproperty
   a_spare_blocked: assert property (p_spare_blocked) else $error("spare flag not forced");

   property p_spare_value;
      i_ce && !spare_block && spare_update |=>
         spare_btn_q == ($past(i_second_result) > $past(i_top_threshold));
   endproperty
   a_spare_value: assert property (p_spare_value) else $error("spare flag wrong");

   property p_spare_hold;
      i_ce && !spare_block && !spare_update |=> $stable(spare_btn_q);
   endproperty
   a_spare_hold: assert property (p_spare_hold) else $error("spare flag moved");

   property p_btn_edge;
      i_ce && edge_init_q && i_bypass_closed && (i_button_request != btn_req_q) |=>
         flags_q[acc_status_pkg::BTN_REQ_IRQ_BIT];
   endproperty
   a_btn_edge: assert property (p_btn_edge) else $error("button edge lost");

   property p_jack_edge;
      i_ce && edge_init_q && (i_jack_detect != jack_q) |=>
         flags_q[acc_status_pkg::JACK_CHG_IRQ_BIT];
   endproperty
   a_jack_edge: assert property (p_jack_edge) else $error("jack edge lost");

   property p_read_clear;
      i_ce && rd_flags |=> flags_q == $past(flag_set);
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not clear");

   property p_irq_mask;
      i_ce ##1 i_ce |-> o_irq == |(flags_q & $past(i_irq_mask));
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt mask wrong");
endmodule : accessory_status_irq_flags

//--- src/level_sync.sv
// Two-flop synchroniser for a group of asynchronous level inputs
`timescale 1ns/10ps
module level_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk, // Block clock
   input wire logic i_rstn, // Async reset, active low
   input wire logic i_ce, // Clock enable
   input wire logic [WIDTH-1:0] i_async, // Asynchronous levels
   output logic [WIDTH-1:0] o_sync // Synchronised levels
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // First stage is read only by the second stage
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (i_ce) begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;

   initial begin
      if (WIDTH < 1 || acc_status_pkg::SYNC_STAGES != 2) begin
         $error("level_sync: unsupported width or depth");
      end
   end
endmodule : level_sync

//--- verif/host_reader.sv
// Host-side model that reads the block's registers one strobe at a time
`timescale 1ns/10ps
module host_reader (
   input wire logic i_clk, // Block clock
   input wire logic [7:0] i_rd_data, // Read result from the block
   input wire logic i_rd_valid, // Read result valid pulse
   output logic o_rd_stb, // Read strobe
   output logic [7:0] o_rd_addr // Read offset
);
   initial begin
      o_rd_stb = 1'b0;
      o_rd_addr = 8'h00;
   end
   // One read; caller enters just after a rising edge, leaves after one idle edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      o_rd_stb = 1'b1;
      o_rd_addr = a;
      @(posedge i_clk);
      #1;
      v = i_rd_valid;
      d = i_rd_data;
      o_rd_stb = 1'b0;
      o_rd_addr = ~a; // Idle offset differs so a stale match cannot pass
      // Idle edge, so a following read raises the strobe afresh
      @(posedge i_clk);
      #1;
   endtask : rd
endmodule : host_reader

//--- verif/test_accessory_status_irq_flags.sv
// Self-checking bench for the accessory status and interrupt flag block
`timescale 1ns/10ps
module test_accessory_status_irq_flags;
   logic i_clk = 1'b0, i_rstn = 1'b0, rd_stb, rd_valid, irq, ce = 1'b1;
   logic thm = 1'b0, sar = 1'b0, btc = 1'b0, mic = 1'b0, byp = 1'b0, sval = 1'b0;
   logic lowg = 1'b0, breq = 1'b0, jack = 1'b0, frz_valid;
   logic [7:0] rd_addr, rd_data, sense = 8'h00, hthr = 8'h00, sres = 8'h00, top = 8'h00;
   logic [7:0] ext = 8'h00, mask = 8'h00, frz_data;
   int fails = 0, n_compared = 0, cycles = 0;
   always #5 i_clk = ~i_clk;
   accessory_status_irq_flags dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce),
      .i_rd_stb(rd_stb), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
      .i_sense_voltage(sense), .i_headset_threshold(hthr), .i_thermal_cmp(thm),
      .i_successive_approx_comparator_state(sar), .i_btn_thr_cmp(btc), .i_mic_over_thr(mic), .i_bypass_closed(byp),
      .i_second_result(sres), .i_second_valid(sval), .i_low_gain(lowg),
      .i_top_threshold(top), .i_button_request(breq), .i_jack_detect(jack),
      .i_ext_events(ext), .i_irq_mask(mask), .o_irq(irq));
   host_reader host (.i_clk(i_clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
      .o_rd_stb(rd_stb), .o_rd_addr(rd_addr));
   task automatic results();
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string m);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : tick
   // Read through the host model, answer must come with its valid pulse
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string m);
      logic [7:0] d;
      logic v;
      host.rd(a, d, v);
      check({7'h00, v}, 8'h01, "read valid");
      check(d, exp, m);
   endtask : rd_chk
   // One second-converter result pulse
   task automatic second(input logic [7:0] r, input logic g);
      sres = r;
      lowg = g;
      sval = 1'b1;
      tick(1);
      sval = 1'b0;
      tick(2);
   endtask : second
   // Hang guard
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         results();
      end
   end
   initial begin
      tick(20);
      i_rstn = 1'b1;
      tick(1);
      rd_chk(acc_status_pkg::AUX_STATUS_OFS, acc_status_pkg::AUX_STATUS_RST, "aux rst");
      rd_chk(acc_status_pkg::IRQ_FLAGS_OFS, acc_status_pkg::IRQ_FLAGS_RST, "irq rst");
      rd_chk(8'h3A, acc_status_pkg::UNMAPPED_DATA, "unmapped");
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         {thm, sar, btc} = 3'h1 << i;
         tick(4);
         rd_chk(8'h05, 8'h10 << i, "mirror");
      end
      {thm, sar, btc} = 3'b000;
      tick(4);
      rd_chk(8'h05, 8'h00, "mirror off");
      sense = 8'h81;
      hthr = 8'h80;
      tick(2);
      rd_chk(8'h05, 8'h80, "hs above");
      sense = 8'h7F;
      tick(2);
      rd_chk(8'h05, 8'h00, "hs below");
      $display("test status done");
      byp = 1'b1;
      top = 8'h90;
      second(8'h91, 1'b1);
      rd_chk(8'h05, 8'h01, "spare set");
      second(8'h90, 1'b1);
      rd_chk(8'h05, 8'h00, "spare equal");
      second(8'h91, 1'b0);
      rd_chk(8'h05, 8'h00, "high gain");
      second(8'h91, 1'b1);
      mic = 1'b1;
      tick(4);
      rd_chk(8'h05, 8'h00, "mic over");
      mic = 1'b0;
      tick(3);
      second(8'h91, 1'b1);
      rd_chk(8'h05, 8'h01, "spare again");
      byp = 1'b0;
      tick(2);
      rd_chk(8'h05, 8'h00, "bypass open");
      $display("test spare done");
      jack = 1'b1;
      tick(2);
      check({7'h00, irq}, 8'h00, "irq masked");
      mask = 8'h02;
      tick(1);
      check({7'h00, irq}, 8'h01, "irq on");
      rd_chk(8'h06, 8'h02, "jack in");
      tick(1);
      check({7'h00, irq}, 8'h00, "irq cleared");
      rd_chk(8'h06, 8'h00, "cleared");
      jack = 1'b0;
      tick(2);
      rd_chk(8'h06, 8'h02, "jack out");
      breq = 1'b1;
      tick(2);
      rd_chk(8'h06, 8'h00, "btn no bypass");
      byp = 1'b1;
      breq = 1'b0;
      tick(2);
      rd_chk(8'h06, 8'h20, "btn release");
      breq = 1'b1;
      tick(2);
      rd_chk(8'h06, 8'h20, "btn press");
      $display("test events done");
      mask = 8'hFF;
      fork
         rd_chk(8'h06, 8'h00, "old flags");
         begin
            ext = 8'h01;
            tick(1);
            ext = 8'h00;
         end
      join
      tick(1);
      check({7'h00, irq}, 8'h01, "pending irq");
      rd_chk(8'h06, 8'h01, "kept event");
      $display("test coincide done");
      // Frozen block takes no read and loses event pulses, but a level change waits
      ce = 1'b0;
      ext = 8'h04;
      tick(1);
      ext = 8'h00;
      jack = 1'b1;
      tick(2);
      check({7'h00, irq}, 8'h00, "frozen irq");
      host.rd(8'h06, frz_data, frz_valid);
      check({7'h00, frz_valid}, 8'h00, "frozen read");
      check(frz_data, 8'h01, "frozen data");
      ce = 1'b1;
      tick(2);
      rd_chk(8'h06, 8'h02, "jack after freeze");
      $display("test freeze done");
      // Reset in mid-run clears flags; first sample after release is no edge
      jack = 1'b0;
      tick(2);
      check({7'h00, irq}, 8'h01, "irq before reset");
      i_rstn = 1'b0;
      tick(2);
      check({7'h00, irq}, 8'h00, "irq in reset");
      jack = 1'b1;
      i_rstn = 1'b1;
      tick(2);
      check({7'h00, irq}, 8'h00, "no edge after reset");
      rd_chk(8'h06, 8'h00, "flags after reset");
      $display("test reset again done");
      results();
   end
endmodule : test_accessory_status_irq_flags
